// ---- rtl/rcfg_defines.vh ----
// constants shared by the radio configuration command block
`ifndef RCFG_DEFINES_VH
`define RCFG_DEFINES_VH

// ----------------------------------------------------------------
// command framing bytes
// ----------------------------------------------------------------
`define RCFG_HEADER 8'hFF
`define RCFG_SIZE 8'h02
`define RCFG_ESCAPE 8'hFE
`define RCFG_ACK 8'h06
`define RCFG_WAKE0 8'h0F
`define RCFG_WAKE1 8'hFF

// ----------------------------------------------------------------
// register locations (volatile and persistent forms)
// ----------------------------------------------------------------
`define RCFG_TRIG_VOL 8'h54
`define RCFG_TRIG_PER 8'h09
`define RCFG_STARTUP_PER 8'h0A
`define RCFG_LBT_VOL 8'h56
`define RCFG_LBT_PER 8'h0B
`define RCFG_PWR_VOL 8'h58
`define RCFG_PWR_PER 8'h0D
`define RCFG_WACK_VOL 8'h59
`define RCFG_WACK_PER 8'h0E
`define RCFG_UID_FIRST 8'h22
`define RCFG_UID_LAST 8'h27
`define RCFG_RELEASE_PER 8'h78

// ----------------------------------------------------------------
// reset values, ranges and encodings
// ----------------------------------------------------------------
`define RCFG_TRIG_RESET 8'h40
`define RCFG_TRIG_MIN 8'h01
`define RCFG_TRIG_MAX 8'h90
`define RCFG_STARTUP_RESET 8'h01
`define RCFG_LBT_RESET 8'h01
`define RCFG_WACK_RESET 8'h01
`define RCFG_PWR_AWAKE 8'h00
`define RCFG_PWR_SLEEP 8'h01
`define RCFG_PWR_STANDBY 8'h02

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// wake delays in core_clk cycles, 8 ms and 2 ms at 125 MHz
`define RCFG_SLEEP_WAKE_CYC 20'd1000000
`define RCFG_STANDBY_WAKE_CYC 20'd250000

`endif

// ---- rtl/rcfg_fifo.v ----
// byte buffer between the serial receive side and the radio
`timescale 1ns/1ps
`default_nettype none

module rcfg_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire core_clk,
   input wire srst,
   input wire in_valid,
   input wire [WIDTH-1:0] in_data,
   output wire in_ready,
   output wire out_valid,
   output wire [WIDTH-1:0] out_data,
   input wire out_ready
);

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;

   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always @(posedge core_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ---- rtl/rcfg_timer.v ----
// loadable down-counter that pulses done when it expires
`timescale 1ns/1ps
`default_nettype none

module rcfg_timer #(
   parameter W = 20
) (
   input wire core_clk,
   input wire srst,
   input wire load,
   input wire [W-1:0] load_val,
   output wire busy,
   output reg done
);

   reg [W-1:0] cnt_reg;

   assign busy = (cnt_reg != {W{1'b0}});

   always @(posedge core_clk) begin
      if (srst) begin
         cnt_reg <= {W{1'b0}};
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt_reg <= load_val;
         end else if (busy) begin
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
               done <= 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ---- rtl/rcfg_top.v ----
// serial command interpreter and configuration registers of the radio module
// ----------------------------------------------------------------
// Summary of operation
// [R01] start packet when buffered count reaches level
// [R02] trigger level range 1..144, default 64
// [R03] escaped read answers ack, location, value
// [R04] four-byte write stores value at location
// [R05] start-up message sent after reset if enabled
// [R06] listen-before-talk defers start while channel busy
// [R07] listen-before-talk enable, default enabled
// [R08] power state: awake, sleep, standby
// [R09] sleep: radio off, slow processor, long wake
// [R10] standby: only oscillator on, short wake
// [R11] radio data dropped while asleep
// [R12] byte sequence 0F FF FF wakes device
// [R13] waking clears power state to awake
// [R14] ack byte after wake or power-up
// [R15] wake acknowledge enable, default enabled
// [R16] six identifier bytes, escaped read only
// [R17] identifier bytes never change
// [R18] release code readable at its location
// [R19] bytes passed to radio at once; start flagged when count reaches level
// [R20] out-of-range trigger level write ignored
// [R21] writes to read-only locations ignored
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "rcfg_defines.vh"

module rcfg_top #(
   parameter [47:0] UNIQUE_ID = 48'h0123_4567_89AB,
   parameter [7:0] RELEASE_CODE = 8'h00,
   parameter [7:0] STARTUP_BYTE0 = 8'h52,
   parameter [7:0] STARTUP_BYTE1 = 8'h4D,
   parameter FIFO_DEPTH = 16,
   parameter [19:0] SLEEP_WAKE_CYC = `RCFG_SLEEP_WAKE_CYC,
   parameter [19:0] STANDBY_WAKE_CYC = `RCFG_STANDBY_WAKE_CYC
) (
   input wire core_clk,
   input wire srst,
   input wire host_rx_valid,
   input wire [7:0] host_rx_data,
   output reg host_rx_ready,
   output wire host_tx_valid,
   output wire [7:0] host_tx_data,
   input wire host_tx_ready,
   output wire rf_tx_valid,
   output wire [7:0] rf_tx_data,
   input wire rf_tx_ready,
   output reg rf_tx_start,
   input wire channel_busy,
   input wire rf_rx_in_valid,
   input wire [7:0] rf_rx_in_data,
   output reg rf_rx_valid,
   output reg [7:0] rf_rx_data,
   output reg radio_power_on,
   output reg radio_osc_on,
   output reg proc_low_speed,
   output reg device_ready
);

   // ----------------------------------------------------------------
   // parser states
   // ----------------------------------------------------------------
   localparam [2:0] P_IDLE = 3'b000;
   localparam [2:0] P_HDR = 3'b001;
   localparam [2:0] P_SIZE = 3'b010;
   localparam [2:0] P_ESC = 3'b011;
   localparam [2:0] P_WVAL = 3'b100;

   reg [2:0] pst_reg;
   reg [7:0] persistent_location_reg;
   reg [7:0] tx_trigger_level_reg;
   reg [7:0] startup_message_enable_reg;
   reg [7:0] listen_before_talk_enable_reg;
   reg [7:0] power_state_control_reg;
   reg [7:0] wake_acknowledge_enable_reg;
   reg [7:0] pkt_count_reg;
   reg pkt_pend_reg;
   reg [1:0] wk_st_reg;
   reg boot_msg_pend_reg;
   reg boot_ack_pend_reg;
   reg wake_ack_pend_reg;
   reg [23:0] tx_q_reg;
   reg [1:0] tx_cnt_reg;
   reg busy_meta_reg;
   reg busy_sync_reg;
   reg [7:0] value_byte;

   wire rx_take;
   wire asleep;
   wire wake_busy;
   wire wake_done;
   wire awake_cmd;
   wire fifo_in_valid;
   wire fifo_in_ready;
   wire fifo_push;
   wire rd_load;
   wire wake_seen;
   wire tx_pop;
   wire lbt_on;
   wire [7:0] pkt_count_inc;

   assign asleep = (power_state_control_reg != `RCFG_PWR_AWAKE);
   assign awake_cmd = !asleep && !wake_busy;
   assign rx_take = host_rx_valid && host_rx_ready;
   assign lbt_on = (listen_before_talk_enable_reg == 8'h01);
   assign pkt_count_inc = pkt_count_reg + 8'h01;

   // ----------------------------------------------------------------
   // channel busy synchroniser
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         busy_meta_reg <= 1'b0;
         busy_sync_reg <= 1'b0;
      end else begin
         busy_meta_reg <= channel_busy;
         busy_sync_reg <= busy_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // receive acceptance
   // ----------------------------------------------------------------
   always @* begin
      if (asleep) begin
         host_rx_ready = 1'b1;
      end else if (wake_busy) begin
         host_rx_ready = 1'b0;
      end else if (pst_reg == P_IDLE && host_rx_data != `RCFG_HEADER) begin
         host_rx_ready = fifo_in_ready;
      end else if (pst_reg == P_ESC) begin
         host_rx_ready = (tx_cnt_reg == 2'b00);
      end else begin
         host_rx_ready = 1'b1;
      end
   end

   assign fifo_in_valid = host_rx_valid && awake_cmd && pst_reg == P_IDLE && host_rx_data != `RCFG_HEADER;
   assign fifo_push = fifo_in_valid && fifo_in_ready;
   assign rd_load = rx_take && awake_cmd && pst_reg == P_ESC;

   // ----------------------------------------------------------------
   // command parser
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         pst_reg <= P_IDLE;
         persistent_location_reg <= 8'h00;
      end else if (asleep || !awake_cmd) begin
         pst_reg <= P_IDLE;
      end else if (rx_take) begin
         case (pst_reg)
            P_IDLE: begin
               if (host_rx_data == `RCFG_HEADER) begin
                  pst_reg <= P_HDR;
               end
            end
            P_HDR: begin
               pst_reg <= (host_rx_data == `RCFG_SIZE) ? P_SIZE : P_IDLE;
            end
            P_SIZE: begin
               if (host_rx_data == `RCFG_ESCAPE) begin
                  pst_reg <= P_ESC; // [R03]
               end else begin
                  persistent_location_reg <= host_rx_data; // [R04]
                  pst_reg <= P_WVAL;
               end
            end
            P_ESC: begin
               pst_reg <= P_IDLE;
            end
            P_WVAL: begin
               pst_reg <= P_IDLE; // [R21]
            end
            default: begin
               pst_reg <= P_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read value selection
   // ----------------------------------------------------------------
   always @* begin
      case (host_rx_data)
         `RCFG_TRIG_VOL, `RCFG_TRIG_PER: value_byte = tx_trigger_level_reg;
         `RCFG_STARTUP_PER: value_byte = startup_message_enable_reg;
         `RCFG_LBT_VOL, `RCFG_LBT_PER: value_byte = listen_before_talk_enable_reg;
         `RCFG_PWR_VOL, `RCFG_PWR_PER: value_byte = power_state_control_reg;
         `RCFG_WACK_VOL, `RCFG_WACK_PER: value_byte = wake_acknowledge_enable_reg;
         8'h22: value_byte = UNIQUE_ID[47:40]; // [R16]
         8'h23: value_byte = UNIQUE_ID[39:32];
         8'h24: value_byte = UNIQUE_ID[31:24];
         8'h25: value_byte = UNIQUE_ID[23:16];
         8'h26: value_byte = UNIQUE_ID[15:8];
         8'h27: value_byte = UNIQUE_ID[7:0];
         `RCFG_RELEASE_PER: value_byte = RELEASE_CODE; // [R18]
         default: value_byte = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         tx_trigger_level_reg <= `RCFG_TRIG_RESET; // [R02]
         startup_message_enable_reg <= `RCFG_STARTUP_RESET;
         listen_before_talk_enable_reg <= `RCFG_LBT_RESET; // [R07]
         power_state_control_reg <= `RCFG_PWR_AWAKE;
         wake_acknowledge_enable_reg <= `RCFG_WACK_RESET; // [R15]
      end else if (wake_seen) begin
         power_state_control_reg <= `RCFG_PWR_AWAKE; // [R13]
      end else if (rx_take && awake_cmd && pst_reg == P_WVAL) begin
         case (persistent_location_reg)
            `RCFG_TRIG_VOL, `RCFG_TRIG_PER: begin
               if (host_rx_data >= `RCFG_TRIG_MIN && host_rx_data <= `RCFG_TRIG_MAX) begin
                  tx_trigger_level_reg <= host_rx_data; // [R20]
               end
            end
            `RCFG_STARTUP_PER: begin
               startup_message_enable_reg <= host_rx_data; // [R05]
            end
            `RCFG_LBT_VOL, `RCFG_LBT_PER: begin
               listen_before_talk_enable_reg <= host_rx_data;
            end
            `RCFG_PWR_VOL, `RCFG_PWR_PER: begin
               if (host_rx_data <= `RCFG_PWR_STANDBY) begin
                  power_state_control_reg <= host_rx_data; // [R08]
               end
            end
            `RCFG_WACK_VOL, `RCFG_WACK_PER: begin
               wake_acknowledge_enable_reg <= host_rx_data;
            end
            default: begin
               // identifier and release locations are fixed
               tx_trigger_level_reg <= tx_trigger_level_reg; // [R17]
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // wake sequence detector and wake-up delay
   // ----------------------------------------------------------------
   assign wake_seen = asleep && rx_take && wk_st_reg == 2'b10 && host_rx_data == `RCFG_WAKE1; // [R12]

   always @(posedge core_clk) begin
      if (srst) begin
         wk_st_reg <= 2'b00;
      end else if (!asleep || wake_seen) begin
         wk_st_reg <= 2'b00;
      end else if (rx_take) begin
         if (host_rx_data == `RCFG_WAKE0) begin
            wk_st_reg <= 2'b01;
         end else if (host_rx_data == `RCFG_WAKE1 && wk_st_reg != 2'b00) begin
            wk_st_reg <= 2'b10;
         end else begin
            wk_st_reg <= 2'b00;
         end
      end
   end

   rcfg_timer #(
      .W(20)
   ) u_wake_timer (
      .core_clk(core_clk),
      .srst(srst),
      .load(wake_seen),
      .load_val((power_state_control_reg == `RCFG_PWR_SLEEP) ? SLEEP_WAKE_CYC : STANDBY_WAKE_CYC), // [R09] [R10]
      .busy(wake_busy),
      .done(wake_done)
   );

   // ----------------------------------------------------------------
   // power outputs and radio receive gating
   // ----------------------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         radio_power_on <= 1'b0;
         radio_osc_on <= 1'b0;
         proc_low_speed <= 1'b0;
         device_ready <= 1'b0;
         rf_rx_valid <= 1'b0;
         rf_rx_data <= 8'h00;
      end else begin
         radio_power_on <= !asleep; // [R09] [R10]
         radio_osc_on <= (power_state_control_reg != `RCFG_PWR_SLEEP);
         proc_low_speed <= asleep;
         device_ready <= awake_cmd;
         rf_rx_valid <= rf_rx_in_valid && awake_cmd; // [R11]
         if (rf_rx_in_valid && awake_cmd) begin
            rf_rx_data <= rf_rx_in_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // data buffer and packet trigger
   // ----------------------------------------------------------------
   rcfg_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(4)
   ) u_fifo (
      .core_clk(core_clk),
      .srst(srst),
      .in_valid(fifo_in_valid),
      .in_data(host_rx_data),
      .in_ready(fifo_in_ready),
      .out_valid(rf_tx_valid),
      .out_data(rf_tx_data),
      .out_ready(rf_tx_ready)
   );

   always @(posedge core_clk) begin
      if (srst) begin
         pkt_count_reg <= 8'h00;
         pkt_pend_reg <= 1'b0;
         rf_tx_start <= 1'b0;
      end else begin
         rf_tx_start <= 1'b0;
         if (pkt_pend_reg && awake_cmd && !(lbt_on && busy_sync_reg)) begin // [R06]
            rf_tx_start <= 1'b1;
            pkt_pend_reg <= 1'b0;
         end
         if (fifo_push) begin
            if (pkt_count_inc >= tx_trigger_level_reg) begin
               pkt_count_reg <= 8'h00;
               pkt_pend_reg <= 1'b1; // [R01] [R19]
            end else begin
               pkt_count_reg <= pkt_count_inc;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // serial transmit queue
   // ----------------------------------------------------------------
   assign host_tx_valid = (tx_cnt_reg != 2'b00);
   assign host_tx_data = tx_q_reg[23:16];
   assign tx_pop = host_tx_valid && host_tx_ready;

   always @(posedge core_clk) begin
      if (srst) begin
         tx_q_reg <= 24'h000000;
         tx_cnt_reg <= 2'b00;
         boot_msg_pend_reg <= 1'b1;
         boot_ack_pend_reg <= 1'b1;
         wake_ack_pend_reg <= 1'b0;
      end else begin
         if (tx_pop) begin
            tx_q_reg <= {tx_q_reg[15:0], 8'h00};
            tx_cnt_reg <= tx_cnt_reg - 2'b01;
         end else if (tx_cnt_reg == 2'b00) begin
            if (rd_load) begin
               tx_q_reg <= {`RCFG_ACK, host_rx_data, value_byte}; // [R03]
               tx_cnt_reg <= 2'b11;
            end else if (boot_msg_pend_reg) begin
               boot_msg_pend_reg <= 1'b0;
               if (startup_message_enable_reg != 8'h00) begin
                  tx_q_reg <= {STARTUP_BYTE0, STARTUP_BYTE1, RELEASE_CODE}; // [R05]
                  tx_cnt_reg <= 2'b11;
               end
            end else if (boot_ack_pend_reg || (wake_ack_pend_reg && !wake_done)) begin
               boot_ack_pend_reg <= 1'b0;
               wake_ack_pend_reg <= 1'b0;
               if (wake_acknowledge_enable_reg == 8'h01) begin
                  tx_q_reg <= {`RCFG_ACK, 16'h0000}; // [R14]
                  tx_cnt_reg <= 2'b01;
               end
            end
         end
         if (wake_done) begin
            wake_ack_pend_reg <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ---- testbench/rcfg_checker.sv ----
// concurrent checks on the ports of the radio configuration command block
`timescale 1ns/1ps
`default_nettype none
module rcfg_checker (
   input wire core_clk,
   input wire srst,
   input wire host_rx_ready,
   input wire host_tx_valid,
   input wire [7:0] host_tx_data,
   input wire host_tx_ready,
   input wire rf_tx_start,
   input wire rf_rx_in_valid,
   input wire [7:0] rf_rx_in_data,
   input wire rf_rx_valid,
   input wire [7:0] rf_rx_data,
   input wire radio_power_on,
   input wire radio_osc_on,
   input wire proc_low_speed,
   input wire device_ready
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);

   a_awake_full_speed: assert property (radio_power_on |-> radio_osc_on && !proc_low_speed)
      else $error("awake outputs wrong");
   a_sleep_radio_off: assert property (!$past(srst) && !radio_osc_on |-> !radio_power_on && proc_low_speed)
      else $error("sleep state outputs wrong");
   a_standby_osc_only: assert property (!$past(srst) && radio_osc_on && !radio_power_on |-> proc_low_speed)
      else $error("standby state outputs wrong");
   a_ready_when_awake: assert property (device_ready |-> radio_power_on)
      else $error("ready while radio off");
   a_wake_delay_stall: assert property (radio_power_on && !device_ready |-> !$past(host_rx_ready))
      else $error("byte taken in wake delay");
   a_rf_rx_dropped: assert property (!device_ready |-> !rf_rx_valid)
      else $error("radio byte passed while not ready");
   a_rf_rx_forward: assert property (rf_rx_in_valid ##1 device_ready |-> rf_rx_valid && rf_rx_data == $past(rf_rx_in_data))
      else $error("radio byte not forwarded");
   a_tx_byte_hold: assert property (host_tx_valid && !host_tx_ready |=> host_tx_valid && $stable(host_tx_data))
      else $error("answer byte changed");
   a_start_awake: assert property (rf_tx_start |-> radio_power_on)
      else $error("packet start while radio off");

   c_start: cover property (rf_tx_start);
   c_wake: cover property ($fell(proc_low_speed));
   c_tx_stall: cover property (host_tx_valid && !host_tx_ready);
endmodule

bind rcfg_top rcfg_checker i_chk (
   .core_clk(core_clk),
   .srst(srst),
   .host_rx_ready(host_rx_ready),
   .host_tx_valid(host_tx_valid),
   .host_tx_data(host_tx_data),
   .host_tx_ready(host_tx_ready),
   .rf_tx_start(rf_tx_start),
   .rf_rx_in_valid(rf_rx_in_valid),
   .rf_rx_in_data(rf_rx_in_data),
   .rf_rx_valid(rf_rx_valid),
   .rf_rx_data(rf_rx_data),
   .radio_power_on(radio_power_on),
   .radio_osc_on(radio_osc_on),
   .proc_low_speed(proc_low_speed),
   .device_ready(device_ready)
);
`default_nettype wire

// ---- testbench/rcfg_host_model.sv ----
// host controller model on the serial command port
`timescale 1ns/1ps
`default_nettype none
module rcfg_host_model (
   input wire logic core_clk,
   output var logic host_rx_valid,
   output var logic [7:0] host_rx_data,
   input wire logic host_rx_ready,
   input wire logic host_tx_valid,
   input wire logic [7:0] host_tx_data,
   output var logic host_tx_ready
);
   initial begin
      host_rx_valid = 1'b0;
      host_rx_data = 8'hA5;
      host_tx_ready = 1'b0;
   end
   // byte held until the device takes it
   task send(input logic [7:0] b);
      begin
         @(negedge core_clk);
         host_rx_valid = 1'b1;
         host_rx_data = b;
         #1;
         while (host_rx_ready !== 1'b1) begin
            @(negedge core_clk);
            #1;
         end
         @(posedge core_clk);
      end
   endtask
   // present a byte and report whether it would be taken
   task offer(input logic [7:0] b, output logic rdy);
      begin
         @(negedge core_clk);
         host_rx_valid = 1'b1;
         host_rx_data = b;
         #1;
         rdy = host_rx_ready;
      end
   endtask
   // released data line shows a changed value, not the last byte
   task idle;
      begin
         @(negedge core_clk);
         host_rx_valid = 1'b0;
         host_rx_data = ~host_rx_data;
      end
   endtask
   // take one answer byte, optionally after stalling
   task recv(input int stall, output logic [7:0] b);
      begin
         repeat (stall) @(negedge core_clk);
         @(negedge core_clk);
         host_tx_ready = 1'b1;
         #1;
         while (host_tx_valid !== 1'b1) begin
            @(negedge core_clk);
            #1;
         end
         b = host_tx_data;
         @(posedge core_clk);
         host_tx_ready <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the radio configuration command block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
   localparam [47:0] UID = 48'hA1B2C3D4E5F6; // arbitrary
   localparam [7:0] REL = 8'h3C; // arbitrary
   reg core_clk = 1'b0;
   reg srst = 1'b1;
   reg rf_tx_ready = 1'b1;
   reg channel_busy = 1'b0;
   reg rf_rx_in_valid = 1'b0;
   reg [7:0] rf_rx_in_data = 8'h00;
   wire host_rx_valid, host_rx_ready, host_tx_valid, host_tx_ready, rf_tx_valid, rf_tx_start, rf_rx_valid;
   wire radio_power_on, radio_osc_on, proc_low_speed, device_ready;
   wire [7:0] host_rx_data, host_tx_data, rf_tx_data, rf_rx_data;
   int n_fail = 0;
   int compares = 0;
   int starts = 0;
   int pops = 0;
   int rxs = 0;
   int i, s0;
   reg [7:0] b, last_pop, last_rx;
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (rf_tx_start === 1'b1)
         starts <= starts + 1;
      if (rf_tx_valid === 1'b1 && rf_tx_ready === 1'b1) begin
         pops <= pops + 1;
         last_pop <= rf_tx_data;
      end
      if (rf_rx_valid === 1'b1) begin
         rxs <= rxs + 1;
         last_rx <= rf_rx_data;
      end
   end
   rcfg_top #(.UNIQUE_ID(UID), .RELEASE_CODE(REL), .SLEEP_WAKE_CYC(20'd20), .STANDBY_WAKE_CYC(20'd8)) i_dut (
      .core_clk(core_clk), .srst(srst), .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data),
      .host_rx_ready(host_rx_ready), .host_tx_valid(host_tx_valid), .host_tx_data(host_tx_data),
      .host_tx_ready(host_tx_ready), .rf_tx_valid(rf_tx_valid), .rf_tx_data(rf_tx_data),
      .rf_tx_ready(rf_tx_ready), .rf_tx_start(rf_tx_start), .channel_busy(channel_busy),
      .rf_rx_in_valid(rf_rx_in_valid), .rf_rx_in_data(rf_rx_in_data), .rf_rx_valid(rf_rx_valid),
      .rf_rx_data(rf_rx_data), .radio_power_on(radio_power_on), .radio_osc_on(radio_osc_on),
      .proc_low_speed(proc_low_speed), .device_ready(device_ready)
   );
   rcfg_host_model i_host (
      .core_clk(core_clk), .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data),
      .host_rx_ready(host_rx_ready), .host_tx_valid(host_tx_valid), .host_tx_data(host_tx_data),
      .host_tx_ready(host_tx_ready)
   );
   task finish_test;
      begin
         if (n_fail == 0 && compares > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task ticks(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task seq(input [31:0] w, input int n);
      begin
         for (int k = n - 1; k >= 0; k--)
            i_host.send(w[8 * k +: 8]);
         i_host.idle;
      end
   endtask
   task wr(input [7:0] loc, input [7:0] v);
      seq({8'hFF, 8'h02, loc, v}, 4);
   endtask
   task rd(input [7:0] loc, input [7:0] v);
      begin
         seq({8'hFF, 8'h02, 8'hFE, loc}, 4);
         i_host.recv(loc[0] ? 3 : 0, b);
         `CHK("rd_ack", 8'h06, b)
         i_host.recv(0, b);
         `CHK("rd_loc", loc, b)
         i_host.recv(0, b);
         `CHK("rd_val", v, b)
      end
   endtask
   task rf_in(input [7:0] d);
      begin
         @(negedge core_clk);
         rf_rx_in_valid = 1'b1;
         rf_rx_in_data = d;
         @(negedge core_clk);
         rf_rx_in_valid = 1'b0;
         rf_rx_in_data = ~d;
      end
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      finish_test;
   end
   initial begin
      ticks(8);
      srst = 1'b0;
      for (i = 0; i < 4; i++) begin
         i_host.recv(0, b);
         `CHK("startup", (i == 0) ? 8'h52 : (i == 1) ? 8'h4D : (i == 2) ? REL : 8'h06, b)
      end
      rd(8'h54, 8'h40);
      rd(8'h09, 8'h40);
      rd(8'h0A, 8'h01);
      rd(8'h56, 8'h01);
      rd(8'h0B, 8'h01);
      rd(8'h58, 8'h00);
      rd(8'h0D, 8'h00);
      rd(8'h59, 8'h01);
      rd(8'h0E, 8'h01);
      rd(8'h78, REL);
      rd(8'h30, 8'h00);
      for (i = 0; i < 6; i++)
         rd(8'h22 + i[7:0], UID[47 - 8 * i -: 8]);
      wr(8'h54, 8'h10);
      rd(8'h09, 8'h10);
      wr(8'h09, 8'h00);
      rd(8'h54, 8'h10);
      wr(8'h54, 8'h91);
      rd(8'h54, 8'h10);
      wr(8'h54, 8'h90);
      rd(8'h54, 8'h90);
      wr(8'h0A, 8'h00);
      rd(8'h0A, 8'h00);
      wr(8'h24, 8'h00);
      rd(8'h24, UID[31:24]);
      wr(8'h78, 8'h00);
      rd(8'h78, REL);
      wr(8'h56, 8'h00);
      wr(8'h54, 8'h04);
      s0 = starts;
      seq(32'h111213, 3);
      ticks(10);
      `CHK("early_start", s0, starts)
      seq(8'h44, 1);
      ticks(10);
      `CHK("start", s0 + 1, starts)
      `CHK("last_pop", 8'h44, last_pop)
      wr(8'h56, 8'h01);
      channel_busy = 1'b1;
      s0 = starts;
      seq(32'h50515253, 4);
      ticks(20);
      `CHK("lbt_hold", s0, starts)
      channel_busy = 1'b0;
      ticks(10);
      `CHK("lbt_go", s0 + 1, starts)
      wr(8'h54, 8'h90);
      rf_tx_ready = 1'b0;
      s0 = pops;
      for (i = 0; i < 16; i++)
         i_host.send(8'h60 + i[7:0]);
      i_host.offer(8'h77, b[0]);
      `CHK("fifo_full", 1'b0, b[0])
      ticks(2);
      rf_tx_ready = 1'b1;
      seq(8'h77, 1);
      ticks(30);
      `CHK("drained", s0 + 17, pops)
      `CHK("empty", 1'b0, rf_tx_valid)
      wr(8'h58, 8'h01);
      ticks(2);
      `CHK("sleep_pwr", 3'b001, {radio_power_on, radio_osc_on, proc_low_speed})
      s0 = rxs;
      rf_in(8'h3A);
      ticks(2);
      `CHK("sleep_drop", s0, rxs)
      seq(32'h0FFFFF, 3);
      i_host.recv(0, b);
      `CHK("wake_ack", 8'h06, b)
      rd(8'h58, 8'h00);
      rf_in(8'h3B);
      ticks(2);
      `CHK("rx_fwd", 8'h3B, last_rx)
      wr(8'h0E, 8'h00);
      wr(8'h0D, 8'h02);
      ticks(2);
      `CHK("stby_pwr", 3'b011, {radio_power_on, radio_osc_on, proc_low_speed})
      seq(32'h0FFFFF, 3);
      for (i = 0; i < 40; i++) begin
         ticks(1);
         `CHK("no_ack", 1'b0, host_tx_valid)
      end
      `CHK("ready", 1'b1, device_ready)
      rd(8'h59, 8'h00);
      finish_test;
   end
endmodule
`default_nettype wire
